// *** src/nibble_crossbar_defines.svh ***
// nibble_crossbar_defines.svh: register offsets, field positions and reset values of the nibble crossbar.
// assumes a 32-bit avalon-mm slave with byte addresses; included by bare name.
`ifndef NIBBLE_CROSSBAR_DEFINES_SVH
`define NIBBLE_CROSSBAR_DEFINES_SVH

// register byte offsets
`define BANK1_LOW_OFFSET     5'h00
`define BANK1_HIGH_OFFSET    5'h04
`define BANK2_LOW_OFFSET     5'h08
`define BANK2_HIGH_OFFSET    5'h0C
`define STORED_LOW_OFFSET    5'h10
`define STORED_HIGH_OFFSET   5'h14

// field layout: eight select nibbles per 32-bit word, nibble j at bits 4j+3..4j
`define NIBBLES_PER_WORD     8
`define HIGH_WORD_BASE       4'h8
`define HALF_SWAP_XOR        4'h8

// reset values and the read value of unmapped offsets
`define OE_N_RESET           16'hFFFF
`define WAITREQ_RESET        1'b1
`define READ_UNMAPPED        32'h0000_0000

`endif

// *** src/nibble_crossbar_pkg.sv ***
// nibble_crossbar_pkg: types shared by the crossbar control and its checker.
// assumes nothing of its surroundings.
package nibble_crossbar_pkg;

   typedef logic [3:0]        nibble_t;
   typedef logic [15:0][3:0]  bank_t;

   // source of the multiplexer selects, encoded as on the select pins
   typedef enum logic [1:0] {
      SRC_BANK1    = 2'b00,
      SRC_BANK2    = 2'b01,
      SRC_SWAP     = 2'b10,
      SRC_READBACK = 2'b11
   } mux_source_e;

   // register bus handshake
   typedef enum logic {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_e;

endpackage : nibble_crossbar_pkg

// *** src/nibble_select_mux.sv ***
// nibble_select_mux: one 16-to-1 multiplexer of 4-bit nibbles taken from the 64-bit internal bus.
// assumes the select is already resolved by the caller; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module nibble_select_mux
(
   input  wire logic [63:0] bus_in,
   input  wire logic [3:0]  select_in,
   output logic      [3:0]  nibble_out
);

   // select value n picks bus nibble n
   assign nibble_out = bus_in[{select_in, 2'b00} +: 4];

endmodule : nibble_select_mux

`default_nettype wire

// *** src/nibble_crossbar_control.sv ***
// nibble_crossbar_control: control of a 64-bit crossbar of sixteen nibble multiplexers, two select banks,
// two half input registers and pin or bus loading of the select flops.
// assumes all pins, including the capture and select-flop clocks, are synchronous to clk_in.
// limitation: a pin clock must stay high or low for a whole clk_in period,
// since it is sampled once per cycle and a narrower pulse may be missed.
`timescale 1ns/1ps
`default_nettype none
`include "nibble_crossbar_defines.svh"

module nibble_crossbar_control
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        clk_en_in,
   // data pins
   input  wire logic [63:0] data_in,
   output logic      [63:0] data_out,
   output logic      [15:0] data_oe_n_out,
   input  wire logic [15:0] data_nibble_output_enable_n_in,
   input  wire logic        upper_half_capture_clock_in,
   input  wire logic        lower_half_capture_clock_in,
   input  wire logic        upper_stored_input_select_in,
   input  wire logic        lower_stored_input_select_in,
   input  wire logic [1:0]  mux_control_source_select_in,
   // select flop control pins
   input  wire logic        select_flop_clock_in,
   input  wire logic        select_write_n_in,
   input  wire logic [1:0]  select_group_address_in,
   input  wire logic        select_load_source_in,
   input  wire logic        select_load_bank_in,
   input  wire logic        readback_bank_select_in,
   input  wire logic        select_io_output_enable_n_in,
   input  wire logic [15:0] select_io_pins_in,
   output logic      [15:0] select_io_pins_out,
   output logic      [15:0] select_io_pins_oe_n_out,
   // avalon-mm register slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest
);

   ////////////////////////////////////////////////////////////////////////////////
   // state

   // one packed struct holds every flop, so the clock enable covers all of them at once
   typedef struct packed {
      logic [31:0]                     upper_half_r;
      logic [31:0]                     lower_half_r;
      nibble_crossbar_pkg::bank_t      bank1_r;
      nibble_crossbar_pkg::bank_t      bank2_r;
      logic                            upper_clk_q_r;
      logic                            lower_clk_q_r;
      logic                            flop_clk_q_r;
      logic [63:0]                     data_r;
      logic [15:0]                     data_oe_n_r;
      logic [15:0]                     sel_io_r;
      logic [15:0]                     sel_io_oe_n_r;
      nibble_crossbar_pkg::bus_state_e bus_state_r;
      logic                            waitreq_r;
      logic [31:0]                     readdata_r;
   } crossbar_state_s;

   crossbar_state_s s_r;
   crossbar_state_s s_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // internal bus and multiplexers

   logic [31:0]                      upper_bus;
   logic [31:0]                      lower_bus;
   logic [63:0]                      internal_bus;
   logic [63:0]                      stored_bus;
   logic [15:0][3:0]                 mux_select;
   logic [15:0][3:0]                 mux_out;
   nibble_crossbar_pkg::mux_source_e source_mode;

   // each half from live pins or its stored register
   assign upper_bus    = upper_stored_input_select_in ? s_r.upper_half_r : data_in[63:32];
   assign lower_bus    = lower_stored_input_select_in ? s_r.lower_half_r : data_in[31:0];
   assign internal_bus = {upper_bus, lower_bus};
   assign stored_bus   = {s_r.upper_half_r, s_r.lower_half_r};
   assign source_mode  = nibble_crossbar_pkg::mux_source_e'(mux_control_source_select_in);

   // per-nibble select source; readback ignores the mux so its select is a don't-care zero
   // the swap pattern is a constant per nibble, so it costs no flops and no load time
   genvar g;
   generate
      for (g = 0; g < 16; g++)
      begin : g_mux
         always_comb
         begin
            unique case (source_mode)
               nibble_crossbar_pkg::SRC_BANK1:    mux_select[g] = s_r.bank1_r[g];
               nibble_crossbar_pkg::SRC_BANK2:    mux_select[g] = s_r.bank2_r[g];
               nibble_crossbar_pkg::SRC_SWAP:     mux_select[g] = 4'(g) ^ `HALF_SWAP_XOR;
               nibble_crossbar_pkg::SRC_READBACK: mux_select[g] = 4'h0;
            endcase
         end

         // any number of nibbles may carry the same select, which gives broadcast
         nibble_select_mux u_mux
         (
            .bus_in     (internal_bus),
            .select_in  (mux_select[g]),
            .nibble_out (mux_out[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic

   logic upper_edge;
   logic lower_edge;
   logic flop_edge;
   logic pin_load;
   logic bus_load;
   logic reg_write;
   logic hit_bank1;
   logic hit_bank2;
   logic hit_high;

   // the pin clocks are sampled levels, so their rising edges become one-cycle strobes
   assign upper_edge = upper_half_capture_clock_in & ~s_r.upper_clk_q_r;
   assign lower_edge = lower_half_capture_clock_in & ~s_r.lower_clk_q_r;
   assign flop_edge  = select_flop_clock_in & ~s_r.flop_clk_q_r;
   assign pin_load   = flop_edge & ~select_write_n_in & ~select_load_source_in;
   assign bus_load   = flop_edge & ~select_write_n_in & select_load_source_in;
   assign reg_write  = (s_r.bus_state_r == nibble_crossbar_pkg::BUS_ANSWER) & avs_write;

   // bank word decode; the stored-half words answer reads only, writes to them are dropped
   assign hit_bank1  = (avs_address == `BANK1_LOW_OFFSET) || (avs_address == `BANK1_HIGH_OFFSET);
   assign hit_bank2  = (avs_address == `BANK2_LOW_OFFSET) || (avs_address == `BANK2_HIGH_OFFSET);
   assign hit_high   = (avs_address == `BANK1_HIGH_OFFSET) || (avs_address == `BANK2_HIGH_OFFSET);

   always_comb
   begin
      nibble_crossbar_pkg::bank_t load_bank;
      logic [3:0]                 base;
      load_bank = '0;
      base      = 4'h0;
      s_nxt     = s_r;

      // edge detectors track the pins on every enabled cycle
      s_nxt.upper_clk_q_r = upper_half_capture_clock_in;
      s_nxt.lower_clk_q_r = lower_half_capture_clock_in;
      s_nxt.flop_clk_q_r  = select_flop_clock_in;

      // halves are captured on their own strobes, never together by force
      if (upper_edge)
         s_nxt.upper_half_r = data_in[63:32];
      if (lower_edge)
         s_nxt.lower_half_r = data_in[31:0];

      // software writes to the banks, eight nibbles per word with byte-lane masking
      if (reg_write)
      begin
         base = hit_high ? `HIGH_WORD_BASE : 4'h0;
         // a byte lane covers two nibbles; lanes left low keep their nibbles
         for (int j = 0; j < `NIBBLES_PER_WORD; j++)
         begin
            if (avs_byteenable[j / 2])
            begin
               if (hit_bank1)
                  s_nxt.bank1_r[base + 4'(j)] = avs_writedata[4 * j +: 4];
               else if (hit_bank2)
                  s_nxt.bank2_r[base + 4'(j)] = avs_writedata[4 * j +: 4];
            end
         end
      end

      // pin or bus loads come last so that they win over a software write in the same cycle
      load_bank = select_load_bank_in ? s_nxt.bank2_r : s_nxt.bank1_r;
      // the group address staggers the nibbles: one from each group of four
      if (pin_load)
      begin
         for (int k = 0; k < 4; k++)
            load_bank[4 * k + int'(select_group_address_in)] = select_io_pins_in[4 * k +: 4];
      end
      if (bus_load)
      begin
         // the controller must hold the whole bus steady, all nibbles land together
         // a half taken from its stored register lets a pattern arrive in two steps
         for (int i = 0; i < 16; i++)
            load_bank[i] = internal_bus[4 * (int'(4'(i) ^ `HALF_SWAP_XOR)) +: 4];
      end
      if (pin_load || bus_load)
      begin
         if (select_load_bank_in)
            s_nxt.bank2_r = load_bank;
         else
            s_nxt.bank1_r = load_bank;
      end

      // data pins: mux result or stored register echo, enables follow the pins
      // the enables are only copied; avoiding a fight on a pin is the controller's duty
      for (int i = 0; i < 16; i++)
      begin
         if (source_mode == nibble_crossbar_pkg::SRC_READBACK)
            s_nxt.data_r[4 * i +: 4] = stored_bus[4 * i +: 4];
         else
            s_nxt.data_r[4 * i +: 4] = mux_out[i];
      end
      s_nxt.data_oe_n_r = data_nibble_output_enable_n_in;

      // readback of the addressed group on the select pins
      // the banks as they stood before this edge, so readback trails a load by a cycle
      for (int k = 0; k < 4; k++)
      begin
         if (readback_bank_select_in)
            s_nxt.sel_io_r[4 * k +: 4] = s_r.bank2_r[4 * k + int'(select_group_address_in)];
         else
            s_nxt.sel_io_r[4 * k +: 4] = s_r.bank1_r[4 * k + int'(select_group_address_in)];
      end
      s_nxt.sel_io_oe_n_r = {16{select_io_output_enable_n_in}};

      // avalon slave: one wait cycle, then the answer with waitrequest low
      // answering only from idle costs a cycle per request but needs no queue
      unique case (s_r.bus_state_r)
         nibble_crossbar_pkg::BUS_IDLE:
         begin
            s_nxt.waitreq_r = `WAITREQ_RESET;
            if (avs_read || avs_write)
            begin
               s_nxt.bus_state_r = nibble_crossbar_pkg::BUS_ANSWER;
               s_nxt.waitreq_r   = 1'b0;
               unique case (avs_address)
                  `BANK1_LOW_OFFSET:   s_nxt.readdata_r = s_r.bank1_r[7:0];
                  `BANK1_HIGH_OFFSET:  s_nxt.readdata_r = s_r.bank1_r[15:8];
                  `BANK2_LOW_OFFSET:   s_nxt.readdata_r = s_r.bank2_r[7:0];
                  `BANK2_HIGH_OFFSET:  s_nxt.readdata_r = s_r.bank2_r[15:8];
                  `STORED_LOW_OFFSET:  s_nxt.readdata_r = s_r.lower_half_r;
                  `STORED_HIGH_OFFSET: s_nxt.readdata_r = s_r.upper_half_r;
                  default:             s_nxt.readdata_r = `READ_UNMAPPED;
               endcase
            end
         end
         nibble_crossbar_pkg::BUS_ANSWER:
         begin
            // master releases the request after this edge
            s_nxt.bus_state_r = nibble_crossbar_pkg::BUS_IDLE;
            s_nxt.waitreq_r   = `WAITREQ_RESET;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers; clock enable low freezes everything
   // reset wins over the clock enable, so a frozen block can still be cleared

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         s_r               <= '0;
         s_r.data_oe_n_r   <= `OE_N_RESET;
         s_r.sel_io_oe_n_r <= `OE_N_RESET;
         s_r.waitreq_r     <= `WAITREQ_RESET;
      end
      else if (clk_en_in)
      begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flops
   // nothing between these flops and the pins, so output timing never depends on inputs
   assign data_out                = s_r.data_r;
   assign data_oe_n_out           = s_r.data_oe_n_r;
   assign select_io_pins_out      = s_r.sel_io_r;
   assign select_io_pins_oe_n_out = s_r.sel_io_oe_n_r;
   assign avs_readdata            = s_r.readdata_r;
   assign avs_waitrequest         = s_r.waitreq_r;

endmodule : nibble_crossbar_control

`default_nettype wire

// *** verif/nibble_crossbar_control_checker.sv ***
// nibble_crossbar_control_checker: port-level properties of the crossbar control.
// assumes clk_en_in falls only while the watched pins stand still, and no register write beside a select-flop load.
`timescale 1ns/1ps
`default_nettype none
module nibble_crossbar_control_checker
(
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic [63:0] data_in,
   input wire logic [63:0] data_out,
   input wire logic [15:0] data_nibble_output_enable_n_in,
   input wire logic [15:0] data_oe_n_out,
   input wire logic        upper_stored_input_select_in,
   input wire logic        lower_stored_input_select_in,
   input wire logic [1:0]  mux_control_source_select_in,
   input wire logic        select_flop_clock_in,
   input wire logic        select_write_n_in,
   input wire logic [1:0]  select_group_address_in,
   input wire logic        select_load_source_in,
   input wire logic        select_load_bank_in,
   input wire logic        readback_bank_select_in,
   input wire logic        select_io_output_enable_n_in,
   input wire logic [15:0] select_io_pins_in,
   input wire logic [15:0] select_io_pins_out,
   input wire logic [15:0] select_io_pins_oe_n_out,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest
);
   default clocking main_cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////////////////////////
   // pin load into the bank shown on readback; strobe-high edge; quiet follow-up cycle
   sequence pin_load_s;
      $rose(select_flop_clock_in) && !select_write_n_in && !select_load_source_in
         && (readback_bank_select_in == select_load_bank_in);
   endsequence
   sequence blocked_load_s;
      $rose(select_flop_clock_in) && select_write_n_in;
   endsequence
   sequence held_s;
      $stable(select_group_address_in) && $stable(readback_bank_select_in) && !avs_write;
   endsequence
   ////////////////////////////////////////////////////////////
   // pin-level relations; the past-reset guard skips the first edge after release
   data_enable_copy_a: assert property (
      !$past(rst_in) |-> data_oe_n_out == $past(data_nibble_output_enable_n_in))
      else $error("data enable copy wrong");
   select_enable_copy_a: assert property (
      !$past(rst_in) |-> select_io_pins_oe_n_out == {16{$past(select_io_output_enable_n_in)}})
      else $error("select pin enable copy wrong");
   half_swap_a: assert property (
      mux_control_source_select_in == nibble_crossbar_pkg::SRC_SWAP && !upper_stored_input_select_in
      && !lower_stored_input_select_in |=> data_out == {$past(data_in[31:0]), $past(data_in[63:32])})
      else $error("half swap output wrong");
   pin_load_a: assert property (
      pin_load_s ##1 held_s |=> select_io_pins_out == $past(select_io_pins_in, 2))
      else $error("pin load not read back");
   write_inhibit_a: assert property (
      blocked_load_s ##1 held_s |=> $stable(select_io_pins_out))
      else $error("inhibited load changed a bank");
   bus_answer_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");
   answer_cause_a: assert property (
      $fell(avs_waitrequest) |-> $past(avs_read || avs_write))
      else $error("answer without request");
   unmapped_read_a: assert property (
      avs_read && avs_waitrequest && avs_address > 5'h17 |=> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
endmodule : nibble_crossbar_control_checker
bind nibble_crossbar_control nibble_crossbar_control_checker nibble_crossbar_control_checker_inst (.*);
`default_nettype wire

// *** verif/select_controller_model.sv ***
// select_controller_model: the external controller driving the data and select pins.
// assumes the bench resolves the shared wires; every change is a nonblocking assignment after clk_in.
`timescale 1ns/1ps
`default_nettype none
module select_controller_model
(
   input  wire logic        clk_in,
   output logic      [63:0] dat_out = 64'h0,
   output logic      [15:0] pins_out = 16'h0,
   output logic      [15:0] data_nibble_output_enable_n_in = 16'hFFFF,
   output logic             upper_half_capture_clock_in = 1'h0,
   output logic             lower_half_capture_clock_in = 1'h0,
   output logic             upper_stored_input_select_in = 1'h0,
   output logic             lower_stored_input_select_in = 1'h0,
   output logic      [1:0]  mux_control_source_select_in = 2'h0,
   output logic             select_flop_clock_in = 1'h0,
   output logic             select_write_n_in = 1'h1,
   output logic      [1:0]  select_group_address_in = 2'h0,
   output logic             select_load_source_in = 1'h0,
   output logic             select_load_bank_in = 1'h0,
   output logic             readback_bank_select_in = 1'h0,
   output logic             select_io_output_enable_n_in = 1'h1
);
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick
   ////////////////////////////////////////////////////////////
   // one select-flop load; qualifiers held across the edge, then a low sample before the next
   task automatic load(input logic src, bnk, wn, input logic [1:0] g, input logic [15:0] p);
      select_load_source_in <= src;
      select_load_bank_in <= bnk;
      readback_bank_select_in <= bnk;
      select_write_n_in <= wn;
      select_group_address_in <= g;
      pins_out <= p;
      select_io_output_enable_n_in <= 1'h1;
      tick(1);
      select_flop_clock_in <= 1'h1;         // all 64 bus bits already stand
      tick(1);
      select_flop_clock_in <= 1'h0;
      tick(1);
   endtask : load
   // capture one half; every nibble stays an input meanwhile
   task automatic capture(input logic up, input logic [63:0] v);
      data_nibble_output_enable_n_in <= 16'hFFFF;
      dat_out <= v;
      tick(1);
      upper_half_capture_clock_in <= up;
      lower_half_capture_clock_in <= !up;
      tick(1);
      upper_half_capture_clock_in <= 1'h0;
      lower_half_capture_clock_in <= 1'h0;
      tick(1);
   endtask : capture
   // select source, enables, stored-half selects and pin data, then let outputs settle
   task automatic setup(input logic [1:0] m, input logic [15:0] oe, input logic us, ls, input logic [63:0] v);
      mux_control_source_select_in <= m;
      data_nibble_output_enable_n_in <= oe;
      upper_stored_input_select_in <= us;
      lower_stored_input_select_in <= ls;
      dat_out <= v;
      tick(3);
   endtask : setup
   // release the select pins so the design shows one group of a bank
   task automatic look(input logic rb, input logic [1:0] g);
      readback_bank_select_in <= rb;
      select_group_address_in <= g;
      select_io_output_enable_n_in <= 1'h0;
      tick(3);
   endtask : look
endmodule : select_controller_model
`default_nettype wire

// *** verif/test_nibble_crossbar_control.sv ***
// test_nibble_crossbar_control: scoreboard bench for the crossbar control.
// assumes the controller model and the bound checker of this folder.
`timescale 1ns/1ps
`default_nettype none
`include "nibble_crossbar_defines.svh"
module test_nibble_crossbar_control;
   localparam logic [63:0] SWAP = 64'h7654_3210_FEDC_BA98;
   typedef struct {string n; int k; logic [63:0] v;} note_s;
   note_s       notes[$];
   note_s       nt;
   int          seed = 20253;
   int          mismatches = 0;
   int          checks_done = 0;
   logic        clk_in = 1'h0, rst_in = 1'h1, avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
   logic [4:0]  avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, w, rd;
   logic [3:0]  avs_byteenable = 4'hF;
   logic        clk_en_in = 1'h1;
   logic [63:0] data_in, data_out, dat_out, a, b, st, d;
   logic [15:0] data_nibble_output_enable_n_in, data_oe_n_out, pins_out, select_io_pins_in;
   logic [15:0] select_io_pins_out, select_io_pins_oe_n_out;
   logic [1:0]  mux_control_source_select_in, select_group_address_in;
   logic        upper_half_capture_clock_in, lower_half_capture_clock_in, upper_stored_input_select_in;
   logic        lower_stored_input_select_in, select_flop_clock_in, select_write_n_in, select_load_source_in;
   logic        select_load_bank_in, readback_bank_select_in, select_io_output_enable_n_in;
   select_controller_model ctl (.*);
   nibble_crossbar_control nibble_crossbar_control_inst (.*);
   initial
   begin
      forever #12.5 clk_in = ~clk_in;
   end
   // shared wires: design drives a nibble while its enable is low, else the controller, else noise
   always_comb
   begin
      for (int i = 0; i < 16; i++)
         data_in[4*i+:4] = !data_oe_n_out[i] ? data_out[4*i+:4]
                         : data_nibble_output_enable_n_in[i] ? dat_out[4*i+:4] : ~dat_out[4*i+:4];
      select_io_pins_in = !select_io_pins_oe_n_out[0] ? select_io_pins_out
                        : select_io_output_enable_n_in ? pins_out : ~pins_out;
   end
   ////////////////////////////////////////////////////////////
   function automatic logic [63:0] route(input logic [63:0] v, s);
      logic [63:0] r;
      for (int i = 0; i < 16; i++) r[4*i+:4] = v[4*s[4*i+:4]+:4];
      return r;
   endfunction : route
   function automatic logic [15:0] grp(input logic [63:0] p, input int g);
      logic [15:0] r;
      for (int k = 0; k < 4; k++) r[4*k+:4] = p[16*k+4*g+:4];
      return r;
   endfunction : grp
   task automatic note(input string n, input int k, input logic [63:0] v);
      notes.push_back('{n, k, v});
   endtask : note
   task automatic check(input string n, input logic [63:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   // register bus cycle held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] wd);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= ad;
      avs_writedata <= wd;
      @(posedge clk_in);
      while (avs_waitrequest !== 1'h0)
         @(posedge clk_in);
      rd = avs_readdata; // read data taken at the edge that sees waitrequest low
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge clk_in);
   endtask : bus
   ////////////////////////////////////////////////////////////
   // the output watcher: each note names the output that answers it
   always @(negedge clk_in)
      while (notes.size() > 0)
      begin
         nt = notes.pop_front();
         check(nt.n, nt.k == 0 ? data_out : nt.k == 1 ? {48'h0, select_io_pins_out} : {32'h0, rd}, nt.v);
      end
   // a hang is cut off far beyond the hundred or so cycles the sequence needs
   initial
   begin
      repeat (4000) @(posedge clk_in);
      mismatches++;
      test_done();
   end
   initial
   begin
      repeat (8) @(posedge clk_in);
      rst_in <= 1'h0;
      @(posedge clk_in);
      a = {$random(seed), $random(seed)};
      b = {$random(seed), $random(seed)};
      ctl.capture(1'h1, a);
      ctl.capture(1'h0, b);
      st = {a[63:32], b[31:0]};
      ctl.setup(2'h3, 16'h0000, 1'h0, 1'h0, ~b);
      note("stored echo", 0, st);
      ctl.setup(2'h2, 16'h0000, 1'h1, 1'h1, b);
      note("stored swap", 0, {st[31:0], st[63:32]});
      ctl.setup(2'h2, 16'hFFFF, 1'h0, 1'h0, a);
      for (int g = 0; g < 4; g++)
         ctl.load(1'h0, 1'h0, 1'h0, g[1:0], grp(SWAP, g));
      ctl.load(1'h0, 1'h0, 1'h1, 2'h0, 16'h0000);
      d = {$random(seed), $random(seed)};
      ctl.setup(2'h0, 16'hFFFF, 1'h0, 1'h0, d);
      note("bank one route", 0, route(d, SWAP));
      for (int g = 0; g < 4; g++)
      begin
         ctl.look(1'h0, g[1:0]);
         note("select readback", 1, {48'h0, grp(SWAP, g)});
      end
      w = $random(seed);
      bus(1'h0, `BANK1_HIGH_OFFSET, 32'h0);
      note("bank one high word", 2, {32'h0, SWAP[63:32]});
      bus(1'h0, 5'h18, 32'h0);
      note("unmapped read", 2, 64'h0);
      bus(1'h1, `BANK2_LOW_OFFSET, w);
      bus(1'h0, `BANK2_LOW_OFFSET, 32'h0);
      note("bank two low word", 2, {32'h0, w});
      avs_byteenable <= 4'h3;
      bus(1'h1, `BANK2_LOW_OFFSET, ~w);
      avs_byteenable <= 4'hF;
      bus(1'h0, `BANK2_LOW_OFFSET, 32'h0);
      note("byte lane write", 2, {32'h0, w[31:16], ~w[15:0]});
      for (int g = 0; g < 4; g++)
         ctl.load(1'h0, 1'h1, 1'h0, g[1:0], 16'h0000);
      ctl.setup(2'h1, 16'h0001, 1'h0, 1'h0, d);
      note("broadcast", 0, {16{d[3:0]}});
      ctl.setup(2'h0, 16'hFFFF, 1'h0, 1'h0, d);
      note("bank one kept", 0, route(d, SWAP));
      clk_en_in <= 1'h0;
      ctl.setup(2'h1, 16'hFFFF, 1'h0, 1'h0, d);
      note("frozen output", 0, route(d, SWAP));
      clk_en_in <= 1'h1;
      ctl.setup(2'h0, 16'hFFFF, 1'h1, 1'h1, d);
      ctl.load(1'h1, 1'h0, 1'h0, 2'h0, 16'h0000);
      ctl.setup(2'h0, 16'hFFFF, 1'h0, 1'h0, a);
      note("bus load route", 0, route(a, {st[31:0], st[63:32]}));
      repeat (2) @(posedge clk_in);
      test_done();
   end
endmodule : test_nibble_crossbar_control
`default_nettype wire
